/* dv/cgo_regs_bench.sv */
`timescale 1ns/1ps
module cgo_regs_bench;
    import cgo_pkg::*;
    logic                                 i_clk, i_rst_b;
    logic                                 i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic                                 o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [CGO_ADDR_W-1:0]                i_awaddr, i_araddr;
    logic [31:0]                          i_wdata, o_rdata;
    logic [3:0]                           i_wstrb;
    logic [3:0]                           strb_sel = 4'hF;
    logic [1:0]                           o_bresp, o_rresp;
    logic                                 i_sample_valid, o_sample_valid;
    logic [CGO_NCH-1:0][CGO_SAMPLE_W-1:0] i_sample, o_sample;
    int                                   miscompares, tests_run;
    int                                   gc[3] = '{31, 10, 0};
    int                                   of[3] = '{5, -3, -512};

    cgo_regs u_cgo_regs (
        .i_clk          (i_clk),
        .i_rst_b        (i_rst_b),
        .i_awvalid      (i_awvalid),
        .i_awaddr       (i_awaddr),
        .o_awready      (o_awready),
        .i_wvalid       (i_wvalid),
        .i_wdata        (i_wdata),
        .i_wstrb        (i_wstrb),
        .o_wready       (o_wready),
        .o_bvalid       (o_bvalid),
        .o_bresp        (o_bresp),
        .i_bready       (i_bready),
        .i_arvalid      (i_arvalid),
        .i_araddr       (i_araddr),
        .o_arready      (o_arready),
        .o_rvalid       (o_rvalid),
        .o_rdata        (o_rdata),
        .o_rresp        (o_rresp),
        .i_rready       (i_rready),
        .i_sample_valid (i_sample_valid),
        .i_sample       (i_sample),
        .o_sample_valid (o_sample_valid),
        .o_sample       (o_sample)
    );

    always #2.5 i_clk = ~i_clk;

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_smp(input logic [13:0] got, input logic [13:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t sample got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang;
        miscompares++;
        $display("[FAIL] %0t handshake timeout", $time);
        print_verdict();
    endtask

    // Handshakes are judged at the falling edge, where every signal is settled.
    task automatic axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= {16'hFFFF, d};
        i_wstrb <= strb_sel;
        {i_awvalid, i_wvalid, i_bready} <= 3'h7;
        for (int n = 0; n < 50; n++) begin
            @(negedge i_clk);
            ta = i_awvalid & o_awready;
            tw = i_wvalid & o_wready;
            tb = o_bvalid;
            if (tb) chk_reg({30'h0, o_bresp}, {30'h0, er}, "write response");
            @(posedge i_clk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
            if (tb) begin
                i_bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        @(posedge i_clk);
        i_araddr <= a;
        {i_arvalid, i_rready} <= 2'h3;
        for (int n = 0; n < 50; n++) begin
            @(negedge i_clk);
            ta = i_arvalid & o_arready;
            tr = o_rvalid;
            if (tr) chk_reg(o_rdata, ed, "read data");
            if (tr) chk_reg({30'h0, o_rresp}, {30'h0, er}, "read response");
            @(posedge i_clk);
            if (ta) i_arvalid <= 1'b0;
            if (tr) begin
                i_rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    function automatic int model(int x, int n, int o, logic [1:0] c);
        int f;
        int r;
        f = c[0] ? $rtoi(10.0 ** (n / 100.0) * 16384.0 + 0.5) : 16384;
        r = (x * f + 8192) >>> 14;
        if (c[1]) r += o;
        return (r > 8191) ? 8191 : ((r < -8192) ? -8192 : r);
    endfunction

    task automatic smp(input int s0, input int s1, input int s2, input logic [1:0] c);
        int s[3];
        s = '{s0, s1, s2};
        @(posedge i_clk);
        for (int k = 0; k < 3; k++) i_sample[k] <= s[k][13:0];
        i_sample_valid <= 1'b1;
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk_reg({31'h0, o_sample_valid}, 32'h1, "sample valid");
        for (int k = 0; k < 3; k++) begin
            chk_smp(o_sample[k], 14'(model(s[k], gc[k], of[k], c)));
        end
    endtask

    task automatic s_reset;
        for (int k = 0; k < 6; k++) begin
            axi_rd(12'h064 + 12'(4 * k), 32'h0, CGO_RESP_OKAY);
        end
        axi_rd(12'h100, 32'h0, CGO_RESP_OKAY);
        axi_rd(12'h104, 32'h0, CGO_RESP_OKAY);
    endtask

    // All written before any read, so two registers sharing storage are caught.
    task automatic s_rw;
        logic [15:0] d;
        for (int k = 0; k < 6; k++) begin
            d = 16'hA5A5 + 16'(k * 16'h1357);
            axi_wr(12'h064 + 12'(4 * k), d, CGO_RESP_OKAY);
        end
        for (int k = 0; k < 6; k++) begin
            d = 16'hA5A5 + 16'(k * 16'h1357);
            axi_rd(12'h064 + 12'(4 * k), {16'h0, d}, CGO_RESP_OKAY);
        end
    endtask

    task automatic s_unmap;
        axi_wr(12'h060, 16'h1234, CGO_RESP_SLV);
        axi_rd(12'h060, 32'h0, CGO_RESP_SLV);
        axi_rd(12'h07C, 32'h0, CGO_RESP_SLV);
    endtask

    task automatic s_path;
        logic [15:0] v;
        for (int k = 0; k < 3; k++) begin
            v = {5'(gc[k]), 1'b0, 10'(of[k])};
            axi_wr(12'h064 + 12'(8 * k), v, CGO_RESP_OKAY);
            axi_wr(12'h068 + 12'(8 * k), {6'h0, v[9:0]}, CGO_RESP_OKAY);
        end
        for (int c = 0; c < 4; c++) begin
            axi_wr(12'h100, 16'(c), CGO_RESP_OKAY);
            smp(1000, -1000, -7900, 2'(c));
            smp(-4096, 3000, 100, 2'(c));
        end
    endtask

    // The path scenario saturates channels 5 and 7; each flag clears on its own bit.
    task automatic s_stat;
        axi_rd(12'h104, 32'h5, CGO_RESP_OKAY);
        axi_wr(12'h104, 16'h0001, CGO_RESP_OKAY);
        axi_rd(12'h104, 32'h4, CGO_RESP_OKAY);
        axi_wr(12'h104, 16'h0004, CGO_RESP_OKAY);
        axi_rd(12'h104, 32'h0, CGO_RESP_OKAY);
        // Upper byte only: the gain code changes, the low offset byte keeps its value.
        strb_sel = 4'h2;
        axi_wr(12'h06C, 16'h1234, CGO_RESP_OKAY);
        strb_sel = 4'hF;
        axi_rd(12'h06C, 32'h000012FD, CGO_RESP_OKAY);
    endtask

    initial begin
        i_clk = 1'b0;
        i_rst_b = 1'b0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_sample_valid} = '0;
        {i_awaddr, i_araddr, i_wdata, i_wstrb, i_sample} = '0;
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clk);
        s_reset();
        s_rw();
        s_unmap();
        s_path();
        s_stat();
        // A second reset in mid-run must bring every written register back to zero.
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clk);
        s_reset();
        print_verdict();
    end
endmodule // cgo_regs_bench

/* dv/cgo_regs_props.sv */
`timescale 1ns/1ps
module cgo_regs_chk
    import cgo_pkg::*;
(
    // Clock and reset
    input wire logic                  i_clk,
    input wire logic                  i_rst_b,
    // Register bus
    input wire logic                  i_awvalid,
    input wire logic                  o_awready,
    input wire logic                  i_wvalid,
    input wire logic                  o_wready,
    input wire logic                  o_bvalid,
    input wire logic                  i_bready,
    input wire logic                  i_arvalid,
    input wire logic [CGO_ADDR_W-1:0] i_araddr,
    input wire logic                  o_arready,
    input wire logic                  o_rvalid,
    input wire logic [31:0]           o_rdata,
    input wire logic [1:0]            o_rresp,
    input wire logic                  i_rready,
    // Sample stream
    input wire logic                  i_sample_valid,
    input wire logic                  o_sample_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Decoded here rather than trusted from the design, so a wrong index shows up.
    logic ar_map;
    assign ar_map = (i_araddr[1:0] == 2'h0) && ((i_araddr[11:2] >= CGO_IDX_BANK0
        && i_araddr[11:2] <= CGO_IDX_CH7C) || i_araddr[11:2] == CGO_IDX_CTRL
        || i_araddr[11:2] == CGO_IDX_STAT);
    property p_rd_answer; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data late");
    property p_rd_once; o_rvalid && i_rready |=> !o_rvalid && o_arready; endproperty
    a_rd_once: assert property (p_rd_once) else $error("read not closed");
    property p_rd_upper; o_rvalid |-> o_rdata[31:16] == 16'h0000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_rd_unmap;
        i_arvalid && o_arready && !ar_map |=> o_rresp == CGO_RESP_SLV && o_rdata == 32'h0;
    endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read accepted");
    property p_rd_map; i_arvalid && o_arready && ar_map |=> o_rresp == CGO_RESP_OKAY; endproperty
    a_rd_map: assert property (p_rd_map) else $error("mapped read refused");
    property p_ar_block; o_rvalid |-> !o_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("second read accepted");
    property p_wr_block; o_bvalid |-> !o_awready && !o_wready; endproperty
    a_wr_block: assert property (p_wr_block) else $error("second write accepted");
    property p_smp_lat; o_sample_valid == $past(i_sample_valid, 2); endproperty
    a_smp_lat: assert property (p_smp_lat) else $error("sample latency wrong");
endmodule // cgo_regs_chk

bind cgo_regs cgo_regs_chk u_cgo_regs_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_rready(i_rready), .i_sample_valid(i_sample_valid), .o_sample_valid(o_sample_valid));

/* rtl/cgo_chan.sv */
`timescale 1ns/1ps
module cgo_chan
    import cgo_pkg::*;
(
    // Clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_b,
    // Settings
    input  wire logic [CGO_GAIN_W-1:0]    i_gain_code,
    input  wire logic [CGO_OFS_W-1:0]     i_offset,
    input  wire logic                     i_gain_apply,
    input  wire logic                     i_offset_apply,
    // Sample stream
    input  wire logic                     i_valid,
    input  wire logic [CGO_SAMPLE_W-1:0]  i_sample,
    output logic                          o_valid,
    output logic [CGO_SAMPLE_W-1:0]       o_sample,
    output logic                          o_sat
);
    localparam int PW = CGO_SAMPLE_W + CGO_MULT_W + 1;
    localparam logic signed [PW-1:0] SMAX = PW'(2 ** (CGO_SAMPLE_W - 1) - 1);
    localparam logic signed [PW-1:0] SMIN = -PW'(2 ** (CGO_SAMPLE_W - 1));

    logic                    valid_q;
    logic [CGO_SAMPLE_W-1:0] sample_q;
    logic                    sat_q;
    logic                    next_valid;
    logic [CGO_SAMPLE_W-1:0] next_sample;
    logic                    next_sat;

    always_comb begin
        logic signed [PW-1:0] factor;
        logic signed [PW-1:0] prod;
        logic signed [PW-1:0] sum;
        factor = i_gain_apply ? PW'(CGO_GAIN_LUT[i_gain_code]) : PW'(CGO_UNITY);
        prod   = PW'($signed(i_sample)) * factor;
        prod   = (prod + PW'(2 ** (CGO_FRAC_W - 1))) >>> CGO_FRAC_W;
        // Offset is sign extended and added at sample weight, one code per output step.
        sum    = prod + (i_offset_apply ? PW'($signed(i_offset)) : '0);
        next_valid  = i_valid;
        next_sat    = 1'b0;
        next_sample = sum[CGO_SAMPLE_W-1:0];
        if (sum > SMAX) begin
            next_sample = SMAX[CGO_SAMPLE_W-1:0];
            next_sat    = i_valid;
        end else if (sum < SMIN) begin
            next_sample = SMIN[CGO_SAMPLE_W-1:0];
            next_sat    = i_valid;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            valid_q  <= 1'b0;
            sample_q <= '0;
            sat_q    <= 1'b0;
        end else begin
            valid_q  <= next_valid;
            sample_q <= next_sample;
            sat_q    <= next_sat;
        end
    end

    assign o_valid  = valid_q;
    assign o_sample = sample_q;
    assign o_sat    = sat_q;
endmodule // cgo_chan

/* rtl/cgo_pkg.sv */
package cgo_pkg;
    localparam int          CGO_NCH        = 3;
    localparam int          CGO_SAMPLE_W   = 14;
    localparam int          CGO_REG_W      = 16;
    localparam int          CGO_ADDR_W     = 12;
    localparam int          CGO_GAIN_LSB   = 11;
    localparam int          CGO_GAIN_W     = 5;
    localparam int          CGO_OFS_LSB    = 0;
    localparam int          CGO_OFS_W      = 10;
    localparam int          CGO_FRAC_W     = 14;
    localparam int          CGO_MULT_W     = 17;
    // Register indices; byte address is four times the index.
    localparam logic [9:0]  CGO_IDX_BANK0  = 10'h019;
    localparam logic [9:0]  CGO_IDX_CH6    = 10'h01B;
    localparam logic [9:0]  CGO_IDX_CH6C   = 10'h01C;
    localparam logic [9:0]  CGO_IDX_CH7    = 10'h01D;
    localparam logic [9:0]  CGO_IDX_CH7C   = 10'h01E;
    localparam logic [9:0]  CGO_IDX_CTRL   = 10'h040;
    localparam logic [9:0]  CGO_IDX_STAT   = 10'h041;
    localparam int          CGO_NSLOT      = 6;
    localparam int          CGO_CTRL_GAIN  = 0;
    localparam int          CGO_CTRL_OFS   = 1;
    localparam logic [15:0] CGO_REG_RESET  = 16'h0000;
    localparam logic [1:0]  CGO_CTRL_RESET = 2'h0;
    localparam logic [1:0]  CGO_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  CGO_RESP_SLV   = 2'h2;
    // Linear factor 10^(N*0.01) in Q2.14 for N = 0..31.
    localparam logic [16:0] CGO_GAIN_LUT [0:31] = '{
        17'h04000, 17'h0417E, 17'h04304, 17'h04494, 17'h0462D, 17'h047CF, 17'h0497B, 17'h04B32,
        17'h04CF2, 17'h04EBD, 17'h05092, 17'h05273, 17'h0545E, 17'h05655, 17'h05858, 17'h05A67,
        17'h05C82, 17'h05EAA, 17'h060DE, 17'h06320, 17'h0656F, 17'h067CC, 17'h06A37, 17'h06CB0,
        17'h06F38, 17'h071CF, 17'h07476, 17'h0772C, 17'h079F3, 17'h07CCA, 17'h07FB2, 17'h082AC};
    localparam logic [16:0] CGO_UNITY      = 17'h04000;
endpackage

/* rtl/cgo_regs.sv */
`timescale 1ns/1ps
module cgo_regs
    import cgo_pkg::*;
(
    // Clock and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_rst_b,
    // AXI4-Lite write address and data
    input  wire logic                                i_awvalid,
    input  wire logic [CGO_ADDR_W-1:0]               i_awaddr,
    output logic                                     o_awready,
    input  wire logic                                i_wvalid,
    input  wire logic [31:0]                         i_wdata,
    input  wire logic [3:0]                          i_wstrb,
    output logic                                     o_wready,
    // AXI4-Lite write response
    output logic                                     o_bvalid,
    output logic [1:0]                               o_bresp,
    input  wire logic                                i_bready,
    // AXI4-Lite read
    input  wire logic                                i_arvalid,
    input  wire logic [CGO_ADDR_W-1:0]               i_araddr,
    output logic                                     o_arready,
    output logic                                     o_rvalid,
    output logic [31:0]                              o_rdata,
    output logic [1:0]                               o_rresp,
    input  wire logic                                i_rready,
    // Samples of channels 5, 6 and 7, lowest index is channel 5
    input  wire logic                                i_sample_valid,
    input  wire logic [CGO_NCH-1:0][CGO_SAMPLE_W-1:0] i_sample,
    output logic                                     o_sample_valid,
    output logic [CGO_NCH-1:0][CGO_SAMPLE_W-1:0]     o_sample
);
    logic [CGO_REG_W-1:0]  bank [CGO_NSLOT];
    logic [CGO_REG_W-1:0]  next_bank [CGO_NSLOT];
    logic [1:0]            ctrl;
    logic [1:0]            next_ctrl;
    logic [CGO_NCH-1:0]    sat_flag;
    logic [CGO_NCH-1:0]    next_sat_flag;
    logic                  aw_held;
    logic                  next_aw_held;
    logic                  w_held;
    logic                  next_w_held;
    logic [9:0]            wr_idx;
    logic [9:0]            next_wr_idx;
    logic [31:0]           wr_data;
    logic [31:0]           next_wr_data;
    logic [3:0]            wr_strb;
    logic [3:0]            next_wr_strb;
    logic                  awready;
    logic                  next_awready;
    logic                  wready;
    logic                  next_wready;
    logic                  bvalid;
    logic                  next_bvalid;
    logic [1:0]            bresp;
    logic [1:0]            next_bresp;
    logic                  arready;
    logic                  next_arready;
    logic                  rvalid;
    logic                  next_rvalid;
    logic [31:0]           rdata;
    logic [31:0]           next_rdata;
    logic [1:0]            rresp;
    logic [1:0]            next_rresp;
    logic [CGO_NCH-1:0]    ch_valid;
    logic [CGO_NCH-1:0]    ch_sat;
    logic [CGO_NCH-1:0][CGO_SAMPLE_W-1:0] ch_sample;
    logic [CGO_NCH-1:0][CGO_SAMPLE_W-1:0] samp_in;
    logic [CGO_NCH-1:0][CGO_SAMPLE_W-1:0] next_samp_in;
    logic                  samp_vin;
    logic                  next_samp_vin;

    // Bank slot of an index, or CGO_NSLOT when the index is not in the bank.
    function automatic int slot_of(input logic [9:0] idx);
        slot_of = CGO_NSLOT;
        if (idx >= CGO_IDX_BANK0 && idx <= CGO_IDX_CH7C) begin
            slot_of = int'(idx - CGO_IDX_BANK0);
        end
    endfunction

    always_comb begin
        int ws;
        int rs;
        ws = slot_of(aw_held ? wr_idx : i_awaddr[11:2]);
        rs = slot_of(i_araddr[11:2]);
        next_bank     = bank;
        next_ctrl     = ctrl;
        next_sat_flag = sat_flag | ch_sat;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_wr_idx   = wr_idx;
        next_wr_data  = wr_data;
        next_wr_strb  = wr_strb;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_rvalid   = rvalid;
        next_rdata    = rdata;
        next_rresp    = rresp;
        if (i_awvalid && awready) begin
            next_aw_held = 1'b1;
            next_wr_idx  = i_awaddr[11:2];
        end
        if (i_wvalid && wready) begin
            next_w_held  = 1'b1;
            next_wr_data = i_wdata;
            next_wr_strb = i_wstrb;
        end
        if (bvalid && i_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = CGO_RESP_OKAY;
            if (ws < CGO_NSLOT) begin
                // All sixteen bits store, reserved ones too, so software reads back what it wrote.
                if (wr_strb[0]) next_bank[ws][7:0]  = wr_data[7:0];
                if (wr_strb[1]) next_bank[ws][15:8] = wr_data[15:8];
            end else if (wr_idx == CGO_IDX_CTRL) begin
                if (wr_strb[0]) next_ctrl = wr_data[1:0];
            end else if (wr_idx == CGO_IDX_STAT) begin
                // A saturation in the clearing cycle keeps its flag set.
                if (wr_strb[0]) next_sat_flag = (sat_flag & ~wr_data[CGO_NCH-1:0]) | ch_sat;
            end else begin
                next_bresp = CGO_RESP_SLV;
            end
        end
        if (rvalid && i_rready) begin
            next_rvalid = 1'b0;
        end
        if (i_arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = CGO_RESP_OKAY;
            next_rdata  = '0;
            if (rs < CGO_NSLOT) begin
                next_rdata = {16'h0000, bank[rs]};
            end else if (i_araddr[11:2] == CGO_IDX_CTRL) begin
                next_rdata = {30'h00000000, ctrl};
            end else if (i_araddr[11:2] == CGO_IDX_STAT) begin
                next_rdata = {29'h00000000, sat_flag};
            end else begin
                next_rresp = CGO_RESP_SLV;
            end
        end
        next_awready  = !next_aw_held && !next_bvalid;
        next_wready   = !next_w_held && !next_bvalid;
        next_arready  = !next_rvalid;
        next_samp_in  = i_sample;
        next_samp_vin = i_sample_valid;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int s = 0; s < CGO_NSLOT; s++) begin
                bank[s] <= CGO_REG_RESET;
            end
            ctrl     <= CGO_CTRL_RESET;
            sat_flag <= '0;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            wr_idx   <= '0;
            wr_data  <= '0;
            wr_strb  <= '0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= CGO_RESP_OKAY;
            arready  <= 1'b0;
            rvalid   <= 1'b0;
            rdata    <= '0;
            rresp    <= CGO_RESP_OKAY;
            samp_in  <= '0;
            samp_vin <= 1'b0;
        end else begin
            bank     <= next_bank;
            ctrl     <= next_ctrl;
            sat_flag <= next_sat_flag;
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            wr_idx   <= next_wr_idx;
            wr_data  <= next_wr_data;
            wr_strb  <= next_wr_strb;
            awready  <= next_awready;
            wready   <= next_wready;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            arready  <= next_arready;
            rvalid   <= next_rvalid;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
            samp_in  <= next_samp_in;
            samp_vin <= next_samp_vin;
        end
    end

    // The pair copy is stored only; the data path trusts software to keep both equal.
    for (genvar c = 0; c < CGO_NCH; c++) begin : g_chan
        cgo_chan u_chan (
            .i_clk          (i_clk),
            .i_rst_b        (i_rst_b),
            .i_gain_code    (bank[2*c][CGO_GAIN_LSB +: CGO_GAIN_W]),
            .i_offset       (bank[2*c][CGO_OFS_LSB +: CGO_OFS_W]),
            .i_gain_apply   (ctrl[CGO_CTRL_GAIN]),
            .i_offset_apply (ctrl[CGO_CTRL_OFS]),
            .i_valid        (samp_vin),
            .i_sample       (samp_in[c]),
            .o_valid        (ch_valid[c]),
            .o_sample       (ch_sample[c]),
            .o_sat          (ch_sat[c])
        );
    end

    assign o_awready      = awready;
    assign o_wready       = wready;
    assign o_bvalid       = bvalid;
    assign o_bresp        = bresp;
    assign o_arready      = arready;
    assign o_rvalid       = rvalid;
    assign o_rdata        = rdata;
    assign o_rresp        = rresp;
    assign o_sample_valid = ch_valid[0];
    assign o_sample       = ch_sample;
endmodule // cgo_regs
